/* hw/ccr_exec_pkg.sv */
// Constants, types and timing for the condition-code and block move core
package ccr_exec_pkg;

	typedef enum logic [4:0] {
		OP_NOP,
		OP_STC_PREDEC,
		OP_AND_CONDITION_CODES,
		OP_ORC,
		OP_XOR_CONDITION_CODES,
		OP_BM_BYTE,
		OP_BM_WORD,
		OP_MOVE_E,
		OP_ADD_W,
		OP_SUB_W,
		OP_ADD_L,
		OP_SUB_L,
		OP_ADDX,
		OP_SUBX,
		OP_DAA,
		OP_DIVXU,
		OP_DIVXS
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_WAIT_E,
		ST_MOVE
	} state_t;

	// Flag positions in condition_code_register
	localparam int CCR_I = 7;
	localparam int CCR_H = 5;
	localparam int CCR_N = 3;
	localparam int CCR_Z = 2;
	localparam int CCR_V = 1;
	localparam int CCR_C = 0;
	localparam logic [7:0] CCR_RESET = 8'h80;

	localparam int HALF_BIT_W = 11;
	localparam int HALF_BIT_L = 27;

	// States per instruction
	localparam logic [3:0] S_STC_PREDEC = 4'h8;
	localparam logic [3:0] S_LOGIC      = 4'h2;
	localparam logic [3:0] S_NOP        = 4'h2;
	localparam logic [3:0] S_BM_SETUP   = 4'h8;
	localparam logic [1:0] S_BM_LAST_PH = 2'h3;
	localparam logic [3:0] S_ARITH      = 4'h2;
	localparam logic [3:0] S_E_MIN      = 4'h2;
	localparam logic [31:0] PREDEC_STEP = 32'h0000_0002;

	function automatic logic [3:0] states_of(input op_t op);
		unique case (op)
			OP_STC_PREDEC: states_of = S_STC_PREDEC;
			OP_AND_CONDITION_CODES, OP_ORC, OP_XOR_CONDITION_CODES: states_of = S_LOGIC;
			OP_NOP: states_of = S_NOP;
			OP_BM_BYTE, OP_BM_WORD: states_of = S_BM_SETUP;
			OP_MOVE_E: states_of = S_E_MIN;
			default: states_of = S_ARITH;
		endcase
	endfunction

endpackage

/* hw/onchip_ram.sv */
// Byte-wide on-chip memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module onchip_ram #(
	parameter int AW = 10
) (
	input  wire logic          clk,   // System clock
	input  wire logic          we,    // Write strobe
	input  wire logic [AW-1:0] addr,  // Byte address
	input  wire logic [7:0]    wdata, // Write byte
	output logic      [7:0]    rdata  // Registered read byte
);
	logic [7:0] mem [0:(1<<AW)-1];

	if (AW < 4 || AW > 16) begin : g_bad_aw
		$error("onchip_ram: AW out of range");
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule
`default_nettype wire

/* hw/ccr_exec_core.sv */
// Execution core for flag stores, flag logic, block moves and flag cases
`timescale 1ns/10ps
`default_nettype none
module ccr_exec_core
	import ccr_exec_pkg::*;
#(
	parameter int AW = 10
) (
	input  wire logic          clk,        // System clock, 50 MHz
	input  wire logic          rst,        // Synchronous reset, high
	input  wire logic          cmd_valid,  // Start instruction when idle
	input  wire op_t           cmd_op,     // Decoded instruction
	input  wire logic [7:0]    cmd_imm,    // 8-bit immediate
	input  wire logic [31:0]   cmd_ptr,    // pointer_register_32 value
	input  wire logic [15:0]   cmd_src,    // source_pointer value
	input  wire logic [15:0]   cmd_dst,    // destination_pointer value
	input  wire logic [15:0]   cmd_count,  // word_count_register value
	input  wire logic [31:0]   cmd_a,      // Arithmetic operand a
	input  wire logic [31:0]   cmd_b,      // Arithmetic operand b
	input  wire logic          e_tick,     // Peripheral clock sync point
	input  wire logic          ext_we,     // Idle memory write strobe
	input  wire logic [AW-1:0] ext_addr,   // Idle memory address
	input  wire logic [7:0]    ext_wdata,  // Idle memory write byte
	output logic      [7:0]    ext_rdata,  // Memory read byte
	output logic               busy,       // Instruction in progress
	output logic               done,       // Instruction finished pulse
	output logic      [7:0]    ccr,        // condition_code_register
	output logic      [31:0]   ptr,        // pointer_register_32
	output logic      [15:0]   src,        // source_pointer
	output logic      [15:0]   dst,        // destination_pointer
	output logic      [15:0]   count,      // word_count_register
	output logic      [31:0]   result      // Arithmetic result
);
	typedef struct packed {
		state_t          st;
		logic [3:0]      cnt;
		logic [1:0]      ph;
		op_t             op;
		logic [7:0]      imm;
		logic [31:0]     a;
		logic [31:0]     b;
		logic [15:0]     left;
		logic [7:0]      ccr;
		logic [31:0]     ptr;
		logic [15:0]     src;
		logic [15:0]     dst;
		logic [15:0]     count;
		logic [31:0]     result;
		logic            busy;
		logic            done;
		logic            mem_we;
		logic [AW-1:0]   mem_addr;
		logic [7:0]      mem_wdata;
	} core_t;

	core_t s_q;
	core_t s_d;
	logic [7:0] mem_rdata;

	onchip_ram #(.AW(AW)) u_ram (
		.clk   (clk),
		.we    (s_q.mem_we),
		.addr  (s_q.mem_addr),
		.wdata (s_q.mem_wdata),
		.rdata (mem_rdata)
	);

	always_comb begin
		logic [12:0] h12;
		logic [28:0] h28;
		logic [16:0] s17;
		logic [32:0] s33;
		logic [8:0]  s9;
		logic [4:0]  h5;
		logic [7:0]  adj;
		logic [8:0]  d9;
		logic [31:0] pdec;
		logic        lo_fix;
		logic        hi_fix;
		logic        cin;
		h12 = '0;
		h28 = '0;
		s17 = '0;
		s33 = '0;
		s9 = '0;
		h5 = '0;
		adj = '0;
		d9 = '0;
		pdec = s_q.ptr - PREDEC_STEP;
		lo_fix = 1'b0;
		hi_fix = 1'b0;
		cin = s_q.ccr[CCR_C];
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.mem_we = 1'b0;
		unique case (s_q.st)
			ST_IDLE: begin
				s_d.mem_we = ext_we;
				s_d.mem_addr = ext_addr;
				s_d.mem_wdata = ext_wdata;
				if (cmd_valid) begin
					s_d.st = ST_EXEC;
					s_d.busy = 1'b1;
					s_d.mem_we = 1'b0;
					s_d.op = cmd_op;
					s_d.imm = cmd_imm;
					s_d.a = cmd_a;
					s_d.b = cmd_b;
					s_d.ptr = cmd_ptr;
					s_d.src = cmd_src;
					s_d.dst = cmd_dst;
					s_d.count = cmd_count;
					s_d.cnt = states_of(cmd_op) - 4'h1;
				end
			end
			ST_EXEC: begin
				if (s_q.cnt != 4'h0) begin
					s_d.cnt = s_q.cnt - 4'h1;
				end else begin
					s_d.st = ST_IDLE;
					s_d.busy = 1'b0;
					s_d.done = 1'b1;
					unique case (s_q.op)
						OP_NOP: begin
							s_d.st = ST_IDLE;
						end
						OP_STC_PREDEC: begin
							s_d.ptr = pdec;
							s_d.mem_we = 1'b1;
							s_d.mem_addr = pdec[AW-1:0];
							s_d.mem_wdata = s_q.ccr;
						end
						OP_AND_CONDITION_CODES: s_d.ccr = s_q.ccr & s_q.imm;
						OP_ORC:  s_d.ccr = s_q.ccr | s_q.imm;
						OP_XOR_CONDITION_CODES: s_d.ccr = s_q.ccr ^ s_q.imm;
						OP_BM_BYTE: begin
							s_d.left = {8'h00, s_q.count[7:0]};
							if (s_q.count[7:0] != 8'h00) begin
								s_d.st = ST_MOVE;
								s_d.busy = 1'b1;
								s_d.done = 1'b0;
								s_d.ph = 2'h0;
							end
						end
						OP_BM_WORD: begin
							s_d.left = s_q.count;
							if (s_q.count != 16'h0000) begin
								s_d.st = ST_MOVE;
								s_d.busy = 1'b1;
								s_d.done = 1'b0;
								s_d.ph = 2'h0;
							end
						end
						OP_MOVE_E: begin
							s_d.st = ST_WAIT_E;
							s_d.busy = 1'b1;
							s_d.done = 1'b0;
						end
						OP_ADD_W, OP_SUB_W: begin
							if (s_q.op == OP_ADD_W) begin
								h12 = {1'b0, s_q.a[11:0]} + {1'b0, s_q.b[11:0]};
								s17 = {1'b0, s_q.a[15:0]} + {1'b0, s_q.b[15:0]};
								s_d.ccr[CCR_V] = (s_q.a[15] == s_q.b[15])
									&& (s17[15] != s_q.a[15]);
							end else begin
								h12 = {1'b0, s_q.a[11:0]} - {1'b0, s_q.b[11:0]};
								s17 = {1'b0, s_q.a[15:0]} - {1'b0, s_q.b[15:0]};
								s_d.ccr[CCR_V] = (s_q.a[15] != s_q.b[15])
									&& (s17[15] != s_q.a[15]);
							end
							s_d.ccr[CCR_H] = h12[HALF_BIT_W+1];
							s_d.ccr[CCR_N] = s17[15];
							s_d.ccr[CCR_Z] = (s17[15:0] == 16'h0000);
							s_d.ccr[CCR_C] = s17[16];
							s_d.result = {16'h0000, s17[15:0]};
						end
						OP_ADD_L, OP_SUB_L: begin
							if (s_q.op == OP_ADD_L) begin
								h28 = {1'b0, s_q.a[27:0]} + {1'b0, s_q.b[27:0]};
								s33 = {1'b0, s_q.a} + {1'b0, s_q.b};
								s_d.ccr[CCR_V] = (s_q.a[31] == s_q.b[31])
									&& (s33[31] != s_q.a[31]);
							end else begin
								h28 = {1'b0, s_q.a[27:0]} - {1'b0, s_q.b[27:0]};
								s33 = {1'b0, s_q.a} - {1'b0, s_q.b};
								s_d.ccr[CCR_V] = (s_q.a[31] != s_q.b[31])
									&& (s33[31] != s_q.a[31]);
							end
							s_d.ccr[CCR_H] = h28[HALF_BIT_L+1];
							s_d.ccr[CCR_N] = s33[31];
							s_d.ccr[CCR_Z] = (s33[31:0] == 32'h0000_0000);
							s_d.ccr[CCR_C] = s33[32];
							s_d.result = s33[31:0];
						end
						OP_ADDX, OP_SUBX: begin
							if (s_q.op == OP_ADDX) begin
								h5 = {1'b0, s_q.a[3:0]} + {1'b0, s_q.b[3:0]}
									+ {4'h0, cin};
								s9 = {1'b0, s_q.a[7:0]} + {1'b0, s_q.b[7:0]}
									+ {8'h00, cin};
								s_d.ccr[CCR_V] = (s_q.a[7] == s_q.b[7])
									&& (s9[7] != s_q.a[7]);
							end else begin
								h5 = {1'b0, s_q.a[3:0]} - {1'b0, s_q.b[3:0]}
									- {4'h0, cin};
								s9 = {1'b0, s_q.a[7:0]} - {1'b0, s_q.b[7:0]}
									- {8'h00, cin};
								s_d.ccr[CCR_V] = (s_q.a[7] != s_q.b[7])
									&& (s9[7] != s_q.a[7]);
							end
							s_d.ccr[CCR_H] = h5[4];
							s_d.ccr[CCR_N] = s9[7];
							if (s9[7:0] != 8'h00) begin
								s_d.ccr[CCR_Z] = 1'b0;
							end
							s_d.ccr[CCR_C] = s9[8];
							s_d.result = {24'h000000, s9[7:0]};
						end
						OP_DAA: begin
							lo_fix = s_q.ccr[CCR_H] || (s_q.a[3:0] > 4'h9);
							hi_fix = s_q.ccr[CCR_C] || (s_q.a[7:0] > 8'h99);
							adj = {(hi_fix ? 4'h6 : 4'h0),
								(lo_fix ? 4'h6 : 4'h0)};
							d9 = {1'b0, s_q.a[7:0]} + {1'b0, adj};
							s_d.ccr[CCR_N] = d9[7];
							s_d.ccr[CCR_Z] = (d9[7:0] == 8'h00);
							if (d9[8]) begin
								s_d.ccr[CCR_C] = 1'b1;
							end
							s_d.result = {24'h000000, d9[7:0]};
						end
						OP_DIVXU: begin
							s_d.ccr[CCR_N] = s_q.b[7];
							s_d.ccr[CCR_Z] = (s_q.b[7:0] == 8'h00);
						end
						OP_DIVXS: begin
							s_d.ccr[CCR_N] = (s_q.b[7:0] != 8'h00)
								&& (s_q.a[15] ^ s_q.b[7]);
							s_d.ccr[CCR_Z] = (s_q.b[7:0] == 8'h00);
						end
						default: s_d.st = ST_IDLE;
					endcase
				end
			end
			ST_WAIT_E: begin
				if (e_tick) begin
					s_d.st = ST_MOVE;
					s_d.ph = 2'h0;
					s_d.left = 16'h0001;
				end
			end
			ST_MOVE: begin
				s_d.ph = s_q.ph + 2'h1;
				unique case (s_q.ph)
					2'h0: s_d.mem_addr = s_q.src[AW-1:0];
					2'h1: s_d.mem_addr = s_q.src[AW-1:0];
					2'h2: begin
						s_d.mem_we = 1'b1;
						s_d.mem_addr = s_q.dst[AW-1:0];
						s_d.mem_wdata = mem_rdata;
					end
					S_BM_LAST_PH: begin
						s_d.src = s_q.src + 16'h0001;
						s_d.dst = s_q.dst + 16'h0001;
						s_d.left = s_q.left - 16'h0001;
						if (s_q.op == OP_BM_BYTE) begin
							s_d.count[7:0] = s_q.count[7:0] - 8'h01;
						end else if (s_q.op == OP_BM_WORD) begin
							s_d.count = s_q.count - 16'h0001;
						end
						if (s_q.left == 16'h0001) begin
							s_d.st = ST_IDLE;
							s_d.busy = 1'b0;
							s_d.done = 1'b1;
						end
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.op <= OP_NOP;
			s_q.ccr <= CCR_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign ext_rdata = mem_rdata;
	assign busy = s_q.busy;
	assign done = s_q.done;
	assign ccr = s_q.ccr;
	assign ptr = s_q.ptr;
	assign src = s_q.src;
	assign dst = s_q.dst;
	assign count = s_q.count;
	assign result = s_q.result;
endmodule
`default_nettype wire

/* dv/ccr_exec_core_asserts.sv */
// Port checker for the flag and block move core
`timescale 1ns/10ps
`default_nettype none
module ccr_exec_core_chk
	import ccr_exec_pkg::*;
(
	input wire logic        clk,       // System clock
	input wire logic        rst,       // Synchronous reset
	input wire logic        cmd_valid, // Start request
	input wire op_t         cmd_op,    // Instruction
	input wire logic [7:0]  cmd_imm,   // Immediate
	input wire logic [31:0] cmd_ptr,   // Pointer at start
	input wire logic [15:0] cmd_count, // Count at start
	input wire logic [31:0] cmd_a,     // Operand a
	input wire logic [31:0] cmd_b,     // Operand b
	input wire logic        busy,      // In progress
	input wire logic        done,      // Finished pulse
	input wire logic [7:0]  ccr,       // Flags
	input wire logic [31:0] ptr        // Pointer
);
	logic [12:0] sum_w;
	logic [28:0] sum_l;
	logic        hc_w;
	logic        hc_l;
	logic        zdiv;
	logic        dgo;
	assign sum_w = {1'b0, cmd_a[11:0]} + {1'b0, cmd_b[11:0]};
	assign sum_l = {1'b0, cmd_a[27:0]} + {1'b0, cmd_b[27:0]};
	assign hc_w = sum_w[12];
	assign hc_l = sum_l[28];
	assign zdiv = (cmd_b[7:0] == 8'h00);
	assign dgo = cmd_valid && !busy
		&& (cmd_op == OP_DIVXU || cmd_op == OP_DIVXS);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_go(op_t o);
		cmd_valid && !busy && cmd_op == o;
	endsequence
	sequence s_busy2;
		busy[*2] ##1 (!busy && done);
	endsequence
	sequence s_busy8;
		busy[*8] ##1 (!busy && done);
	endsequence
	property p_and;
		s_go(OP_AND_CONDITION_CODES) |-> ##3 (ccr == ($past(ccr, 3) & $past(cmd_imm, 3)));
	endproperty
	property p_or;
		s_go(OP_ORC) |-> ##3 (ccr == ($past(ccr, 3) | $past(cmd_imm, 3)));
	endproperty
	property p_xor;
		s_go(OP_XOR_CONDITION_CODES) |-> ##3 (ccr == ($past(ccr, 3) ^ $past(cmd_imm, 3)));
	endproperty
	property p_nop;
		s_go(OP_NOP) |=> s_busy2 ##0 (ccr == $past(ccr, 3));
	endproperty
	property p_stc;
		s_go(OP_STC_PREDEC) |=> s_busy8 ##0 (ptr == $past(cmd_ptr, 9) - 32'h2);
	endproperty
	property p_bm0;
		s_go(OP_BM_WORD) ##0 (cmd_count == 16'h0000) |=> s_busy8;
	endproperty
	property p_hw;
		s_go(OP_ADD_W) |-> ##3 (ccr[CCR_H] == $past(hc_w, 3));
	endproperty
	property p_hl;
		s_go(OP_ADD_L) |-> ##3 (ccr[CCR_H] == $past(hc_l, 3));
	endproperty
	property p_divz;
		dgo |-> ##3 (ccr[CCR_Z] == $past(zdiv, 3));
	endproperty
	property p_done;
		done |-> !busy ##1 !done;
	endproperty
	a_and: assert property (p_and) else $error("and result wrong");
	a_or: assert property (p_or) else $error("or result wrong");
	a_xor: assert property (p_xor) else $error("xor result wrong");
	a_nop: assert property (p_nop) else $error("nop changed flags");
	a_stc: assert property (p_stc) else $error("predec store wrong");
	a_bm0: assert property (p_bm0) else $error("zero move length");
	a_hw: assert property (p_hw) else $error("word half carry");
	a_hl: assert property (p_hl) else $error("long half carry");
	a_divz: assert property (p_divz) else $error("divide zero flag");
	a_done: assert property (p_done) else $error("done not a pulse");
endmodule
bind ccr_exec_core ccr_exec_core_chk u_chk (.clk(clk), .rst(rst),
	.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_imm(cmd_imm),
	.cmd_ptr(cmd_ptr), .cmd_count(cmd_count), .cmd_a(cmd_a),
	.cmd_b(cmd_b), .busy(busy), .done(done), .ccr(ccr), .ptr(ptr));
`default_nettype wire

/* dv/ccr_exec_core_tb_top.sv */
// Self-checking bench for the flag and block move core
`timescale 1ns/10ps
`default_nettype none
module ccr_exec_core_tb_top;
	import ccr_exec_pkg::*;
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
	errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
	logic        clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, e_tick = 1'b0;
	op_t         cmd_op = OP_NOP;
	logic [7:0]  cmd_imm = 8'h00, ext_wdata = 8'h00;
	logic [31:0] cmd_ptr = 32'h0, cmd_a = 32'h0, cmd_b = 32'h0;
	logic [15:0] cmd_src = 16'h0, cmd_dst = 16'h0, cmd_count = 16'h0;
	logic        ext_we = 1'b0;
	logic [9:0]  ext_addr = 10'h000;
	logic [7:0]  ext_rdata, ccr;
	logic        busy, done;
	logic [31:0] ptr, result;
	logic [15:0] src, dst, count;
	int          errors = 0, total_checks = 0, states = 0;
	ccr_exec_core u_ccr_exec_core (.clk(clk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_imm(cmd_imm),
		.cmd_ptr(cmd_ptr), .cmd_src(cmd_src), .cmd_dst(cmd_dst),
		.cmd_count(cmd_count), .cmd_a(cmd_a), .cmd_b(cmd_b),
		.e_tick(e_tick), .ext_we(ext_we), .ext_addr(ext_addr),
		.ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .busy(busy),
		.done(done), .ccr(ccr), .ptr(ptr), .src(src), .dst(dst),
		.count(count), .result(result));
	always #10 clk = ~clk;
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Issue one command, count busy states; st 0 skips the count check
	task automatic run(input op_t op, input int st);
		cmd_op = op;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		states = 0;
		while (busy === 1'b1 && states < 2000) begin
			states++;
			@(negedge clk);
		end
		if (states == 2000) begin
			errors++;
			end_of_test();
		end
		if (st > 0) `CHK("states", st, states)
		`CHK("done", 1'b1, done)
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		ext_addr = a;
		ext_wdata = d;
		ext_we = 1'b1;
		@(negedge clk);
		ext_we = 1'b0;
		// Gap so back-to-back writes never retoggle the strobe at once
		@(negedge clk);
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		ext_addr = a;
		repeat (3) @(negedge clk);
		`CHK("mem", e, ext_rdata)
	endtask
	task automatic setc(input logic [7:0] v);
		cmd_imm = 8'h00;
		run(OP_AND_CONDITION_CODES, 2);
		cmd_imm = v;
		run(OP_ORC, 2);
	endtask
	task automatic fl(input op_t op, input logic [31:0] a, b,
		input int bi, input logic e);
		cmd_a = a;
		cmd_b = b;
		run(op, 2);
		`CHK("flag", e, ccr[bi])
	endtask
	task automatic t_reset();
		`CHK("ccr_rst", 8'h80, ccr)
		`CHK("busy_rst", 1'b0, busy)
	endtask
	task automatic t_logic();
		cmd_imm = 8'h0F;
		run(OP_ORC, 2);
		`CHK("orc", 8'h8F, ccr)
		cmd_imm = 8'hF3;
		run(OP_AND_CONDITION_CODES, 2);
		`CHK("and_condition_codes", 8'h83, ccr)
		cmd_imm = 8'h81;
		run(OP_XOR_CONDITION_CODES, 2);
		`CHK("xor_condition_codes", 8'h02, ccr)
		run(OP_NOP, 2);
		`CHK("nop", 8'h02, ccr)
	endtask
	task automatic t_stc();
		cmd_ptr = 32'h0000_0102;
		run(OP_STC_PREDEC, 8);
		`CHK("ptr", 32'h0000_0100, ptr)
		rd(10'h100, 8'h02);
	endtask
	task automatic t_move();
		wr(10'h010, 8'hA5);
		wr(10'h011, 8'h5A);
		cmd_src = 16'h0010;
		cmd_dst = 16'h0020;
		cmd_count = 16'h0102;
		run(OP_BM_BYTE, 16);
		`CHK("src", 16'h0012, src)
		`CHK("dst", 16'h0022, dst)
		`CHK("cnt", 8'h00, count[7:0])
		rd(10'h020, 8'hA5);
		rd(10'h021, 8'h5A);
		cmd_count = 16'h0000;
		run(OP_BM_WORD, 8);
		`CHK("src0", 16'h0010, src)
		cmd_count = 16'h0001;
		cmd_dst = 16'h0030;
		run(OP_BM_WORD, 12);
		`CHK("cntw", 16'h0000, count)
		rd(10'h030, 8'hA5);
	endtask
	task automatic t_arith();
		fl(OP_ADD_W, 32'h0800, 32'h0800, CCR_H, 1'b1);
		`CHK("sum_w", 32'h0000_1000, result)
		fl(OP_ADD_W, 32'h0400, 32'h0400, CCR_H, 1'b0);
		fl(OP_SUB_W, 32'h1000, 32'h0001, CCR_H, 1'b1);
		fl(OP_ADD_L, 32'h0800_0000, 32'h0800_0000, CCR_H, 1'b1);
		fl(OP_ADD_L, 32'h0000_0800, 32'h0000_0800, CCR_H, 1'b0);
		setc(8'h04);
		fl(OP_ADDX, 32'h0, 32'h0, CCR_Z, 1'b1);
		fl(OP_ADDX, 32'h1, 32'h0, CCR_Z, 1'b0);
		fl(OP_SUBX, 32'h5, 32'h5, CCR_Z, 1'b0);
		setc(8'h01);
		fl(OP_DAA, 32'h12, 32'h0, CCR_C, 1'b1);
		setc(8'h00);
		fl(OP_DAA, 32'h12, 32'h0, CCR_C, 1'b0);
		fl(OP_DAA, 32'h9A, 32'h0, CCR_C, 1'b1);
		`CHK("daa", 32'h0000_0000, result)
		fl(OP_DIVXU, 32'h10, 32'h00, CCR_Z, 1'b1);
		fl(OP_DIVXU, 32'h10, 32'h80, CCR_N, 1'b1);
		fl(OP_DIVXU, 32'h10, 32'h01, CCR_N, 1'b0);
		fl(OP_DIVXS, 32'h8000, 32'h01, CCR_N, 1'b1);
		fl(OP_DIVXS, 32'h0001, 32'h01, CCR_N, 1'b0);
	endtask
	task automatic t_emove();
		cmd_src = 16'h0011;
		cmd_dst = 16'h0040;
		fork
			begin
				repeat (10) @(negedge clk);
				e_tick = 1'b1;
			end
		join_none
		run(OP_MOVE_E, 0);
		e_tick = 1'b0;
		`CHK("ewait", 1'b1, states > 12)
		rd(10'h040, 8'h5A);
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_logic();
		t_stc();
		t_move();
		t_arith();
		t_emove();
		end_of_test();
	end
endmodule
`default_nettype wire
